// ===== design/file_op_compare_skip_exec.sv
// execute unit for the clear, compare-skip, bcd and decrement file ops
// How it works
// - zero_file_op writes zero to the file register and sets zero.
// - kick_timer_op clears watchdog count and postscaler, sets both flags.
// - invert_file_op stores the inverse and updates negative and zero.
// - destination bit 0 sends the result to accumulator, 1 to the file.
// - bank bit 0 uses the direct window, 1 uses the bank_pointer.
// - skip_if_equal_op skips when file equals accumulator, no flags.
// - skip_if_above_op skips when file exceeds accumulator, unsigned.
// - skip_if_below_op skips when file is below accumulator, unsigned.
// - a taken skip turns the fetched word into a nop, two if it is long.
// - bcd_fixup_op adds six per nibble over nine or on carry.
// - decrement_op subtracts one and updates all five arithmetic flags.
// - decrement_skip_nil_op skips on a zero result, flags untouched.
// - decrement_skip_nonnil_op skips on a nonzero result, no flags.
// - q1 decodes, q2 reads, q3 processes, q4 writes the destination.
`timescale 1ns/1ps
module file_op_compare_skip_exec
   import file_op_pkg::*;
#(
   parameter int WDT_W = WDT_WIDTH,
   parameter int PSC_W = PSC_WIDTH
) (
   input  wire logic             ref_clk_in,
   input  wire logic             resetn_in,
   input  wire logic [15:0]      instr_in,
   input  wire logic             instr_valid_in,
   input  wire logic [7:0]       file_rdata_in,
   input  wire logic             wdt_tick_in,
   input  wire logic             sleep_in,
   input  wire logic [3:0]       bank_wdata_in,
   input  wire logic             bank_we_in,
   output logic [1:0]            quarter_out,
   output logic                  instr_ack_out,
   output logic [11:0]           file_addr_out,
   output logic                  file_re_out,
   output logic [7:0]            file_wdata_out,
   output logic                  file_we_out,
   output logic [7:0]            accumulator_out,
   output logic [4:0]            status_out,
   output logic                  watchdog_expiry_flag_out,
   output logic                  sleep_entry_flag_out,
   output logic [WDT_W-1:0]      wdt_count_out,
   output logic [PSC_W-1:0]      wdt_post_out,
   output logic                  skip_out,
   output logic [3:0]            bank_pointer_out
);
   quarter_t          q_r;
   logic [15:0]       ir_r;
   logic              live_r;
   logic [1:0]        nop_r;
   logic [7:0]        opnd_r;
   logic [7:0]        res_r;
   logic [4:0]        stat_r;
   logic [7:0]        acc_r;
   logic              wr_file_r;
   logic              wr_acc_r;
   logic              skip_r;
   logic [3:0]        bank_r;
   logic              to_r;
   logic              pd_r;
   logic [WDT_W-1:0]  wdt_r;
   logic [PSC_W-1:0]  psc_r;
   logic [11:0]       addr_r;
   logic              re_r;
   logic              we_r;
   logic              ack_r;

   // fields of the latched word
   wire [7:0] op_hi = ir_r[15:8];
   wire dbit = ir_r[9];
   wire abit = ir_r[8];
   wire [7:0] f = ir_r[7:0];

   // opcode decode
   wire is_zero  = (op_hi & MASK_A) == OPC_ZERO_FILE;
   wire is_eq    = (op_hi & MASK_A) == OPC_SKIP_EQ;
   wire is_gt    = (op_hi & MASK_A) == OPC_SKIP_ABOVE;
   wire is_lt    = (op_hi & MASK_A) == OPC_SKIP_BELOW;
   wire is_inv   = (op_hi & MASK_DA) == OPC_INVERT;
   wire is_dec   = (op_hi & MASK_DA) == OPC_DECREMENT;
   wire is_dnil  = (op_hi & MASK_DA) == OPC_DEC_NIL;
   wire is_dnon  = (op_hi & MASK_DA) == OPC_DEC_NONNIL;
   wire is_kick  = ir_r == OPC_KICK_TIMER;
   wire is_bcd   = ir_r == OPC_BCD_FIXUP;

   wire is_file  = is_zero | is_eq | is_gt | is_lt | is_inv | is_dec
                 | is_dnil | is_dnon;
   wire has_dest = is_inv | is_dec | is_dnil | is_dnon;
   wire do_op    = live_r;

   // direct window: low half in bank 0, high half in bank 15
   wire [3:0] dir_bank = f[7] ? DIRECT_BANK_HI : DIRECT_BANK_LO;
   wire [3:0] eff_bank = abit ? bank_r : dir_bank;
   wire [11:0] eff_addr = {eff_bank, f};

   // q1 guess of the operand address, refined in q2
   wire [3:0]  pre_dir  = instr_in[7] ? DIRECT_BANK_HI : DIRECT_BANK_LO;
   wire [3:0]  pre_bank = instr_in[8] ? bank_r : pre_dir;
   wire [11:0] pre_addr = {pre_bank, instr_in[7:0]};

   // next word is two-word if its top bits say so
   wire long_top  = instr_in[15:12] == OPC_LONG_HI2;
   wire long_call = instr_in[15:8] == OPC_LONG_CALL;
   wire long_goto = instr_in[15:8] == OPC_LONG_GOTO;
   wire long_load = instr_in[15:8] == OPC_LONG_LFSR;
   wire long_move = instr_in[15:12] == OPC_LONG_HI;
   wire long_nxt  = long_top | long_call | long_goto | long_load
                  | long_move;

   // arithmetic
   wire [7:0] dec_v = opnd_r - 8'h01;
   wire [7:0] inv_v = ~opnd_r;
   wire       dec_c = opnd_r != 8'h00;
   wire       dec_dc = opnd_r[3:0] != 4'h0;
   wire       dec_ov = opnd_r == 8'h80;

   // decimal adjust
   wire lo_adj = acc_r[3:0] > BCD_LIMIT || stat_r[FLAG_DC];
   wire [7:0] bcd_lo = lo_adj ? acc_r + {4'h0, BCD_ADJ} : acc_r;
   wire hi_adj = bcd_lo[7:4] > BCD_LIMIT || stat_r[FLAG_C];
   wire [8:0] bcd_v = hi_adj ? {1'b0, bcd_lo} + {1'b0, BCD_ADJ, 4'h0}
                             : {1'b0, bcd_lo};
   wire bcd_c = bcd_v[8] | stat_r[FLAG_C];

   // result and skip selection
   wire [7:0] alu_v = is_zero ? 8'h00 :
                      is_inv  ? inv_v :
                      is_bcd  ? bcd_v[7:0] :
                      dec_v;
   wire eq_hit   = is_eq && opnd_r == acc_r;
   wire gt_hit   = is_gt && opnd_r > acc_r;
   wire lt_hit   = is_lt && opnd_r < acc_r;
   wire nil_hit  = is_dnil && dec_v == 8'h00;
   wire non_hit  = is_dnon && dec_v != 8'h00;
   wire skip_hit = eq_hit | gt_hit | lt_hit | nil_hit | non_hit;

   // watchdog carries
   wire wdt_wrap = &wdt_r;
   wire psc_wrap = &psc_r;

   wire n_v = alu_v[7];
   wire z_v = alu_v == 8'h00;
   logic [4:0] stat_nxt;
   always_comb begin
      stat_nxt = stat_r;
      if (is_zero) begin
         stat_nxt[FLAG_Z] = 1'b1;
      end else if (is_inv) begin
         stat_nxt[FLAG_N] = n_v;
         stat_nxt[FLAG_Z] = z_v;
      end else if (is_dec) begin
         stat_nxt[FLAG_C]  = dec_c;
         stat_nxt[FLAG_DC] = dec_dc;
         stat_nxt[FLAG_N]  = n_v;
         stat_nxt[FLAG_OV] = dec_ov;
         stat_nxt[FLAG_Z]  = z_v;
      end else if (is_bcd) begin
         stat_nxt[FLAG_C] = bcd_c;
      end
   end
   wire to_acc  = is_bcd || (has_dest && !dbit);
   wire to_file = is_zero || (has_dest && dbit);

   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         q_r <= Q1;
         ack_r <= 1'b0;
      end else begin
         ack_r <= q_r == Q3;
         case (q_r)
            Q1: q_r <= Q2;
            Q2: q_r <= Q3;
            Q3: q_r <= Q4;
            default: q_r <= Q1;
         endcase
      end
   end

   // q1: decode and take the word; skip cycles replace it with a nop
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         ir_r <= 16'h0000;
         live_r <= 1'b0;
         nop_r <= 2'd0;
      end else if (q_r == Q1) begin
         ir_r <= instr_in;
         // a word fetched during a skip is dropped
         live_r <= instr_valid_in && nop_r == 2'd0;
         if (nop_r == 2'd1 && long_nxt) begin
            nop_r <= 2'd2;
         end else begin
            nop_r <= 2'd0;
         end
      end else if (q_r == Q4 && do_op && skip_hit) begin
         nop_r <= 2'd1;
      end
   end

   // q2 read, q3 process, q4 write
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         addr_r <= 12'h000;
         re_r <= 1'b0;
         opnd_r <= 8'h00;
         res_r <= 8'h00;
         wr_file_r <= 1'b0;
         wr_acc_r <= 1'b0;
         skip_r <= 1'b0;
         we_r <= 1'b0;
      end else begin
         re_r <= 1'b0;
         we_r <= 1'b0;
         if (q_r == Q1 && do_op == 1'b0) begin
            skip_r <= 1'b0;
         end
         if (q_r == Q1) begin
            addr_r <= pre_addr;
            re_r <= 1'b0;
            skip_r <= 1'b0;
         end
         if (q_r == Q2 && do_op && is_file) begin
            addr_r <= eff_addr;
            re_r <= 1'b1;
         end
         if (q_r == Q3 && do_op) begin
            opnd_r <= file_rdata_in;
         end
         if (q_r == Q4 && do_op) begin
            res_r <= alu_v;
            wr_file_r <= to_file;
            wr_acc_r <= to_acc;
            we_r <= to_file;
            skip_r <= skip_hit;
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         acc_r <= ACC_RST;
         stat_r <= STATUS_RST;
      end else begin
         if (q_r == Q4 && do_op) begin
            stat_r <= stat_nxt;
            if (to_acc) begin
               acc_r <= alu_v;
            end
         end
      end
   end

   // bank pointer, written from outside
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         bank_r <= BANK_RST;
      end else if (bank_we_in) begin
         bank_r <= bank_wdata_in;
      end
   end

   // watchdog count and postscaler with flags
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         wdt_r <= '0;
         psc_r <= '0;
         to_r <= 1'b1;
         pd_r <= 1'b1;
      end else if (q_r == Q4 && do_op && is_kick) begin
         wdt_r <= '0;
         psc_r <= '0;
         to_r <= 1'b1;
         pd_r <= 1'b1;
      end else begin
         if (sleep_in) begin
            pd_r <= 1'b0;
         end
         if (wdt_tick_in) begin
            wdt_r <= wdt_r + 1'b1;
            if (wdt_wrap) begin
               psc_r <= psc_r + 1'b1;
               if (psc_wrap) begin
                  to_r <= 1'b0;
               end
            end
         end
      end
   end

   assign quarter_out = q_r;
   assign instr_ack_out = ack_r;
   assign file_addr_out = addr_r;
   assign file_re_out = re_r;
   assign file_wdata_out = res_r;
   assign file_we_out = we_r;
   assign accumulator_out = acc_r;
   assign status_out = stat_r;
   assign watchdog_expiry_flag_out = to_r;
   assign sleep_entry_flag_out = pd_r;
   assign wdt_count_out = wdt_r;
   assign wdt_post_out = psc_r;
   assign skip_out = skip_r;
   assign bank_pointer_out = bank_r;
endmodule

// ===== design/file_op_pkg.sv
// package: opcodes, phases and flag positions of the file-op decoder
package file_op_pkg;
   localparam logic [7:0] OPC_ZERO_FILE   = 8'h6a; // 0110 101a, a masked
   localparam logic [7:0] OPC_SKIP_EQ     = 8'h62; // 0110 001a
   localparam logic [7:0] OPC_SKIP_ABOVE  = 8'h64; // 0110 010a
   localparam logic [7:0] OPC_SKIP_BELOW  = 8'h60; // 0110 000a
   localparam logic [7:0] OPC_INVERT      = 8'h1c; // 0001 11da
   localparam logic [7:0] OPC_DECREMENT   = 8'h04; // 0000 01da
   localparam logic [7:0] OPC_DEC_NIL     = 8'h2c; // 0010 11da
   localparam logic [7:0] OPC_DEC_NONNIL  = 8'h4c; // 0100 11da
   localparam logic [15:0] OPC_KICK_TIMER = 16'h0004;
   localparam logic [15:0] OPC_BCD_FIXUP  = 16'h0007;
   localparam logic [7:0] MASK_A          = 8'hfe;
   localparam logic [7:0] MASK_DA         = 8'hfc;
   localparam logic [3:0] OPC_LONG_HI     = 4'hc; // two-word prefixes
   localparam logic [3:0] OPC_LONG_HI2    = 4'hf;
   localparam logic [7:0] OPC_LONG_CALL   = 8'hec;
   localparam logic [7:0] OPC_LONG_GOTO   = 8'hef;
   localparam logic [7:0] OPC_LONG_LFSR   = 8'hee;
   localparam logic [3:0] BCD_LIMIT       = 4'h9;
   localparam logic [3:0] BCD_ADJ         = 4'h6;
   localparam int FLAG_C  = 0;
   localparam int FLAG_DC = 1;
   localparam int FLAG_Z  = 2;
   localparam int FLAG_OV = 3;
   localparam int FLAG_N  = 4;
   localparam logic [4:0] STATUS_RST      = 5'h00;
   localparam logic [7:0] ACC_RST         = 8'h00;
   localparam logic [3:0] BANK_RST        = 4'h0;
   localparam logic [3:0] DIRECT_BANK_LO  = 4'h0;
   localparam logic [3:0] DIRECT_BANK_HI  = 4'hf;
   localparam logic [7:0] DIRECT_SPLIT    = 8'h80;
   localparam int WDT_WIDTH = 16;
   localparam int PSC_WIDTH = 7;
   typedef enum logic [1:0] {Q1, Q2, Q3, Q4} quarter_t;
endpackage

// ===== test/file_op_props.sv
// checker: timing and result properties of the file-op decoder
`timescale 1ns/1ps
module file_op_props
   import file_op_pkg::*;
#(
   parameter int WDT_W = WDT_WIDTH,
   parameter int PSC_W = PSC_WIDTH
) (
   input wire logic             ref_clk_in,
   input wire logic             resetn_in,
   input wire logic [15:0]      instr_in,
   input wire logic             instr_valid_in,
   input wire logic [7:0]       file_rdata_in,
   input wire logic [1:0]       quarter_out,
   input wire logic             file_we_out,
   input wire logic [7:0]       file_wdata_out,
   input wire logic [4:0]       status_out,
   input wire logic             watchdog_expiry_flag_out,
   input wire logic             sleep_entry_flag_out,
   input wire logic [WDT_W-1:0] wdt_count_out,
   input wire logic [PSC_W-1:0] wdt_post_out,
   input wire logic             skip_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);
   wire logic take = quarter_out == 2'd0 && instr_valid_in && !skip_out;
   wire logic [7:0] hi = instr_in[15:8];
   wire logic cmp = (hi & MASK_A) inside
      {OPC_SKIP_EQ, OPC_SKIP_ABOVE, OPC_SKIP_BELOW};
   a_quarter_step: assert property ($past(resetn_in) |->
      quarter_out == $past(quarter_out) + 2'd1) else $error("quarter step");
   a_write_in_q1: assert property (file_we_out |->
      quarter_out == 2'd0) else $error("write outside first quarter");
   a_skip_in_q1: assert property (skip_out |->
      quarter_out == 2'd0) else $error("skip outside first quarter");
   a_zero_writes: assert property (take && (hi & MASK_A) == OPC_ZERO_FILE
      |-> ##4 file_we_out && file_wdata_out == 8'h00 && status_out[FLAG_Z])
      else $error("zero op result");
   a_cmp_flags: assert property (take && cmp |->
      ##4 status_out == $past(status_out, 4)) else $error("compare flags");
   a_kick_clears: assert property (take && instr_in == OPC_KICK_TIMER
      |-> ##4 wdt_count_out == '0 && wdt_post_out == '0
      && watchdog_expiry_flag_out && sleep_entry_flag_out)
      else $error("kick op result");
   a_nil_skip: assert property (take && (hi & MASK_DA) == OPC_DEC_NIL
      |-> ##4 skip_out == ($past(file_rdata_in, 2) == 8'h01))
      else $error("nil skip");
   a_nonnil_skip: assert property (take
      && (hi & MASK_DA) == OPC_DEC_NONNIL
      |-> ##4 skip_out == ($past(file_rdata_in, 2) != 8'h01))
      else $error("nonnil skip");
   a_invert_file: assert property (take && instr_in[9]
      && (hi & MASK_DA) == OPC_INVERT |-> ##4 file_we_out
      && file_wdata_out == ~$past(file_rdata_in, 2)) else $error("invert");
   c_skip: cover property (take && cmp ##4 skip_out);
   c_write: cover property (file_we_out);
   c_kick: cover property (take && instr_in == OPC_KICK_TIMER);
endmodule
bind file_op_compare_skip_exec file_op_props #(
   .WDT_W(WDT_W),
   .PSC_W(PSC_W)
) i_file_op_props (
   .ref_clk_in(ref_clk_in),
   .resetn_in(resetn_in),
   .instr_in(instr_in),
   .instr_valid_in(instr_valid_in),
   .file_rdata_in(file_rdata_in),
   .quarter_out(quarter_out),
   .file_we_out(file_we_out),
   .file_wdata_out(file_wdata_out),
   .status_out(status_out),
   .watchdog_expiry_flag_out(watchdog_expiry_flag_out),
   .sleep_entry_flag_out(sleep_entry_flag_out),
   .wdt_count_out(wdt_count_out),
   .wdt_post_out(wdt_post_out),
   .skip_out(skip_out)
);

// ===== test/testbench.sv
// testbench: directed scenarios for the file-op decoder
`timescale 1ns/1ps
module testbench;
   import file_op_pkg::*;
   logic        ref_clk_in, resetn_in, instr_valid_in, wdt_tick_in;
   logic        sleep_in, bank_we_in, instr_ack_out, file_re_out;
   logic        file_we_out, skip_out, watchdog_expiry_flag_out;
   logic        sleep_entry_flag_out;
   logic [15:0] instr_in, wdt_count_out;
   logic [7:0]  file_rdata_in, file_wdata_out, accumulator_out;
   logic [3:0]  bank_wdata_in, bank_pointer_out;
   logic [1:0]  quarter_out, q_s;
   logic [11:0] file_addr_out;
   logic [4:0]  status_out;
   logic [6:0]  wdt_post_out;
   int          error_cnt = 0;
   int          checks_done = 0;
   file_op_compare_skip_exec i_file_op_compare_skip_exec (.*);
   initial begin
      ref_clk_in = 1'b0;
      forever #25 ref_clk_in = ~ref_clk_in;
   end
   always @(negedge ref_clk_in) q_s <= quarter_out;
   task automatic chk(input string n, input logic [15:0] e, g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic run(input logic [15:0] w, input logic [7:0] fd);
      @(posedge ref_clk_in);
      while (q_s !== 2'd2) @(posedge ref_clk_in);
      instr_in <= w;
      file_rdata_in <= fd;
      instr_valid_in <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      instr_valid_in <= 1'b0;
      repeat (2) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      chk("ack", 16'h1, instr_ack_out);
      @(posedge ref_clk_in);
      @(negedge ref_clk_in);
   endtask
   task automatic run_skip(input logic [15:0] w, w2, w3,
                           input logic [7:0] fd, fd2,
                           output logic sk, output logic [4:0] st,
                           output logic we2, we3);
      @(posedge ref_clk_in);
      while (q_s !== 2'd2) @(posedge ref_clk_in);
      instr_in <= w;
      file_rdata_in <= fd;
      instr_valid_in <= 1'b1;
      repeat (2) @(posedge ref_clk_in);
      instr_valid_in <= 1'b0;
      repeat (2) @(posedge ref_clk_in);
      instr_in <= w2;
      file_rdata_in <= fd2;
      instr_valid_in <= 1'b1;
      @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      sk = skip_out;
      st = status_out;
      @(posedge ref_clk_in);
      instr_in <= w3;
      repeat (3) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      we2 = file_we_out;
      @(posedge ref_clk_in);
      instr_valid_in <= 1'b0;
      repeat (3) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      we3 = file_we_out;
   endtask
   task automatic t_zero();
      @(posedge ref_clk_in);
      bank_wdata_in <= 4'h5;
      bank_we_in <= 1'b1;
      @(posedge ref_clk_in);
      bank_we_in <= 1'b0;
      run({OPC_ZERO_FILE | 8'h01, 8'h33}, 8'h5a);
      chk("we", 16'h1, file_we_out);
      chk("wdata", 16'h0, file_wdata_out);
      chk("zero", 16'h1, status_out[FLAG_Z]);
      chk("addr", 16'h533, file_addr_out);
      chk("bank", 16'h5, bank_pointer_out);
   endtask
   task automatic t_invert();
      run({OPC_INVERT, 8'h90}, 8'h7f);
      chk("acc", 16'h80, accumulator_out);
      chk("we", 16'h0, file_we_out);
      chk("nz", 16'h2, {status_out[FLAG_N], status_out[FLAG_Z]});
      chk("addr", 16'hf90, file_addr_out);
      run({OPC_INVERT | 8'h03, 8'hff}, 8'hff);
      chk("wdata", 16'h0, file_wdata_out);
      chk("nz", 16'h1, {status_out[FLAG_N], status_out[FLAG_Z]});
      chk("addr", 16'h5ff, file_addr_out);
   endtask
   task automatic t_dec();
      run({OPC_DECREMENT, 8'h10}, 8'h80);
      chk("acc", 16'h7f, accumulator_out);
      chk("st", 16'h09, status_out);
      chk("addr", 16'h010, file_addr_out);
      run({OPC_DECREMENT | 8'h02, 8'h10}, 8'h00);
      chk("wdata", 16'hff, file_wdata_out);
      chk("st", 16'h10, status_out);
   endtask
   task automatic t_cmp();
      logic [7:0] ops [3] = '{OPC_SKIP_EQ, OPC_SKIP_ABOVE, OPC_SKIP_BELOW};
      logic [7:0] fds [3] = '{8'h7f, 8'h80, 8'h10};
      logic       e, sk, w2e, w3e;
      logic [4:0] st;
      for (int i = 0; i < 3; i++) begin
         for (int j = 0; j < 3; j++) begin
            e = i == 0 ? fds[j] == 8'h7f : i == 1 ? fds[j] > 8'h7f
               : fds[j] < 8'h7f;
            run_skip({ops[i], 8'h20}, {OPC_DECREMENT | 8'h02, 8'h20},
               {OPC_DECREMENT | 8'h02, 8'h21}, fds[j], 8'h00,
               sk, st, w2e, w3e);
            chk("skip", {15'h0, e}, sk);
            chk("st", 16'h10, st);
            chk("next we", {15'h0, !e}, w2e);
            chk("after we", 16'h1, w3e);
         end
      end
      chk("acc", 16'h7f, accumulator_out);
   endtask
   task automatic t_decskip();
      logic       sk, w2e, w3e;
      logic [4:0] st;
      run({OPC_DEC_NONNIL | 8'h02, 8'h30}, 8'h01);
      chk("skip", 16'h0, skip_out);
      run({OPC_DEC_NIL | 8'h02, 8'h30}, 8'h02);
      chk("skip", 16'h0, skip_out);
      chk("wdata", 16'h01, file_wdata_out);
      run_skip({OPC_DEC_NIL | 8'h02, 8'h30}, 16'hef00,
         {OPC_DECREMENT | 8'h02, 8'h30}, 8'h01, 8'h00, sk, st, w2e, w3e);
      chk("skip", 16'h1, sk);
      chk("st", 16'h10, st);
      chk("long we", 16'h0, w3e);
      run_skip({OPC_DEC_NONNIL | 8'h02, 8'h30}, 16'hef00,
         {OPC_DECREMENT | 8'h02, 8'h30}, 8'h01, 8'h00, sk, st, w2e, w3e);
      chk("skip", 16'h0, sk);
      chk("run we", 16'h1, w3e);
   endtask
   task automatic t_bcd();
      run({OPC_DECREMENT, 8'h40}, 8'h00);
      run({OPC_INVERT, 8'h40}, 8'h5a);
      run(OPC_BCD_FIXUP, 8'h00);
      chk("acc", 16'h05, accumulator_out);
      chk("carry", 16'h1, status_out[FLAG_C]);
   endtask
   task automatic t_kick();
      @(posedge ref_clk_in);
      sleep_in <= 1'b1;
      repeat (3) begin
         wdt_tick_in <= 1'b1;
         @(posedge ref_clk_in);
         wdt_tick_in <= 1'b0;
         @(posedge ref_clk_in);
      end
      sleep_in <= 1'b0;
      @(negedge ref_clk_in);
      chk("sleep", 16'h0, sleep_entry_flag_out);
      run(OPC_KICK_TIMER, 8'h00);
      chk("count", 16'h0, wdt_count_out);
      chk("post", 16'h0, wdt_post_out);
      chk("flags", 16'h3, {watchdog_expiry_flag_out,
         sleep_entry_flag_out});
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #(3000 * 50);
      error_cnt++;
      finish_test();
   end
   initial begin
      resetn_in = 1'b0;
      instr_in = 16'h0000;
      instr_valid_in = 1'b0;
      file_rdata_in = 8'h00;
      wdt_tick_in = 1'b0;
      sleep_in = 1'b0;
      bank_wdata_in = 4'h0;
      bank_we_in = 1'b0;
      repeat (20) @(posedge ref_clk_in);
      resetn_in <= 1'b1;
      t_zero();
      t_invert();
      t_dec();
      t_cmp();
      t_decskip();
      t_bcd();
      t_kick();
      finish_test();
   end
endmodule
